/* src/ssc_pkg.sv */
// package: word layout, select codes and power states of the config port
package ssc_pkg;

    // ------------------------------------------------------------
    // serial word and field widths
    // ------------------------------------------------------------
    localparam int WORD_W = 20;    // bits per serial word
    localparam int REF_W = 15;     // reference divider value
    localparam int SWAL_W = 7;     // swallow count
    localparam int MAIN_W = 11;    // main count
    localparam int CAL_W = 7;      // calibration divider
    localparam int SYNC_W = 7;     // number of pins brought through syncs

    // ------------------------------------------------------------
    // field positions inside a captured word (bit 0 = first word bit)
    // ------------------------------------------------------------
    localparam int SEL_FIRST = 0;  // first select bit, word bit one
    localparam int SEL_SECOND = 1; // second select bit, word bit two
    localparam int REF_LSB = 2;    // reference value, lsb first
    localparam int SWAL_LSB = 2;   // swallow count, lsb first
    localparam int MAIN_LSB = 9;   // main count, lsb first
    localparam int PWR_POS = 2;    // synthesizer power bit
    localparam int PRESC_POS = 4;  // prescaler select
    localparam int CPI_LSB = 5;    // charge pump current, two bits
    localparam int CPS_LSB = 7;    // charge pump sign, two bits
    localparam int LDM_LSB = 9;    // lock pin mux low pair
    localparam int LDM_HI = 15;    // lock pin mux high bit
    localparam int CPT_LSB = 16;   // charge pump test, two bits
    localparam int CAL_LSB = 2;    // calibration divider, lsb first
    localparam int BIAS_POS = 13;  // output bias select

    // ------------------------------------------------------------
    // synchroniser vector slots
    // ------------------------------------------------------------
    localparam int IN_SCLK = 0;
    localparam int IN_SDATA = 1;
    localparam int IN_LOAD = 2;
    localparam int IN_PIN1 = 3;
    localparam int IN_PIN2 = 4;
    localparam int IN_REF = 5;
    localparam int IN_LO = 6;

    // ------------------------------------------------------------
    // prescaler base moduli and reset values
    // ------------------------------------------------------------
    localparam logic [5:0] PRESC_LOW = 6'h10;   // 16/17 setting
    localparam logic [5:0] PRESC_HIGH = 6'h20;  // 32/33 setting
    localparam logic [5:0] PRESC_ONE = 6'h01;   // extra count when swallowing
    localparam logic [19:0] WORD_RST = 20'h00000;

    // target register, {first word bit, second word bit}
    typedef enum logic [1:0] {
        SSC_SEL_REF = 2'h0,
        SSC_SEL_DIV = 2'h1,
        SSC_SEL_MODE = 2'h2,
        SSC_SEL_CAL = 2'h3
    } ssc_sel_t;

    // decoded power state
    typedef enum logic [2:0] {
        SSC_PWR_OFF = 3'h0,   // power bit clear
        SSC_PWR_DOWN = 3'h1,  // both pins low
        SSC_PWR_RX = 3'h2,    // both pins high
        SSC_PWR_TX = 3'h3,    // first high, second low
        SSC_PWR_IDLE = 3'h4   // first low, second high
    } ssc_pwr_t;

endpackage

/* src/ssc_config_port.sv */
// module: three-wire config port, register set, power decode, dividers
// Function
// - sample data on clock rise, msb first
// - shift only while load strobe low
// - strobe rise loads word into target
// - 20-bit word, two low bits select
// - reference value in bits three-seventeen
// - swallow bits three-nine, main ten-twenty
// - mode word field layout
// - calibration divider and bias bit layout
// - swallow count spans zero to 127
// - main count three to 2047
// - reference count three to 32767
// - two prescaler settings, 16/17 and 32/33
// - power bit clear stops loop, loop dividers
// - pins low: power-down, contents kept
// - pins high: receive, loop running
// - first high, second low: transmit
// - first low, second high: idle, loop running
// - reference divided by reference count
// - power bit enables loop, port always on
// - prescaler bit zero 16/17, one 32/33
// - feedback ratio is prescaler*main plus swallow
// - two bits pick charge pump current
module ssc_config_port #(
    parameter int WORD_W = ssc_pkg::WORD_W,
    parameter int REF_W = ssc_pkg::REF_W,
    parameter int SWAL_W = ssc_pkg::SWAL_W,
    parameter int MAIN_W = ssc_pkg::MAIN_W,
    parameter int CAL_W = ssc_pkg::CAL_W
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // three-wire serial port pins
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    // power enable pins
    input wire logic power_pin_first,
    input wire logic power_pin_second,
    // signals to be divided
    input wire logic ref_in,
    input wire logic lo_in,
    // divider settings
    output logic [REF_W-1:0] ref_count,
    output logic [SWAL_W-1:0] swallow_count,
    output logic [MAIN_W-1:0] main_count,
    // mode settings
    output logic synth_power_bit,
    output logic prescaler_sel,
    output logic [1:0] cp_current,
    output logic [1:0] cp_sign,
    output logic [2:0] ld_select,
    output logic [1:0] cp_test,
    // calibration settings
    output logic [CAL_W-1:0] cal_count,
    output logic bias_sel,
    // power status
    output ssc_pkg::ssc_pwr_t power_state,
    output logic loop_active,
    output logic rx_enable,
    output logic tx_enable,
    // divided outputs, one-cycle pulses
    output logic ref_div_pulse,
    output logic lo_div_pulse,
    output logic cal_tick
);

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------

    // true when a counter holds the last count of a divide-by-div
    function automatic logic at_last(input logic [15:0] cnt,
                                     input logic [15:0] div);
        at_last = (cnt + 16'h0001) >= div;
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------

    logic [ssc_pkg::SYNC_W-1:0] pins_raw; // all pins from outside
    logic [ssc_pkg::SYNC_W-1:0] sync1_reg; // first stage, read by sync2
    logic [ssc_pkg::SYNC_W-1:0] sync2_reg; // settled copy
    logic [ssc_pkg::SYNC_W-1:0] sync3_reg; // delayed copy for edges
    logic [ssc_pkg::SYNC_W-1:0] sync1_next;
    logic [ssc_pkg::SYNC_W-1:0] sync2_next;
    logic [ssc_pkg::SYNC_W-1:0] sync3_next;

    // gather pins; the serial clock is sampled, not used as a clock
    always_comb begin
        pins_raw = '0;
        pins_raw[ssc_pkg::IN_SCLK] = serial_clk;
        pins_raw[ssc_pkg::IN_SDATA] = serial_data;
        pins_raw[ssc_pkg::IN_LOAD] = load_strobe;
        pins_raw[ssc_pkg::IN_PIN1] = power_pin_first;
        pins_raw[ssc_pkg::IN_PIN2] = power_pin_second;
        pins_raw[ssc_pkg::IN_REF] = ref_in;
        pins_raw[ssc_pkg::IN_LO] = lo_in;
        sync1_next = pins_raw;
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
    end

    // strobe resets high so no false load follows reset release
    localparam logic [ssc_pkg::SYNC_W-1:0] SYNC_RST =
        ssc_pkg::SYNC_W'(1) << ssc_pkg::IN_LOAD;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= SYNC_RST;
            sync2_reg <= SYNC_RST;
            sync3_reg <= SYNC_RST;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
        end
    end

    // settled levels and edges, all taken after the second stage
    logic sdata_s;
    logic load_s;
    logic pin1_s;
    logic pin2_s;
    logic sclk_rise;
    logic load_rise;
    logic ref_rise;
    logic lo_rise;
    assign sdata_s = sync2_reg[ssc_pkg::IN_SDATA];
    assign load_s = sync2_reg[ssc_pkg::IN_LOAD];
    assign pin1_s = sync2_reg[ssc_pkg::IN_PIN1];
    assign pin2_s = sync2_reg[ssc_pkg::IN_PIN2];
    assign sclk_rise = sync2_reg[ssc_pkg::IN_SCLK] &
                       ~sync3_reg[ssc_pkg::IN_SCLK];
    assign load_rise = load_s & ~sync3_reg[ssc_pkg::IN_LOAD];
    assign ref_rise = sync2_reg[ssc_pkg::IN_REF] &
                      ~sync3_reg[ssc_pkg::IN_REF];
    assign lo_rise = sync2_reg[ssc_pkg::IN_LO] &
                     ~sync3_reg[ssc_pkg::IN_LO];

    // ------------------------------------------------------------
    // serial shifter and register set
    // ------------------------------------------------------------

    logic [WORD_W-1:0] shift_reg; // last bits shifted in
    logic [WORD_W-1:0] ref_reg;   // reference divider word
    logic [WORD_W-1:0] div_reg;   // feedback divider word
    logic [WORD_W-1:0] mode_reg;  // operating mode word
    logic [WORD_W-1:0] cal_reg;   // calibration clock word
    logic [WORD_W-1:0] shift_next;
    logic [WORD_W-1:0] ref_next;
    logic [WORD_W-1:0] div_next;
    logic [WORD_W-1:0] mode_next;
    logic [WORD_W-1:0] cal_next;
    ssc_pkg::ssc_sel_t shift_sel; // target of the word in the shifter

    // word bit one is the last bit in, so it lands in bit 0
    assign shift_sel = ssc_pkg::ssc_sel_t'({shift_reg[ssc_pkg::SEL_FIRST],
                                            shift_reg[ssc_pkg::SEL_SECOND]});

    // shift and load; the register set never needs the loop powered
    always_comb begin
        shift_next = shift_reg;
        ref_next = ref_reg;
        div_next = div_reg;
        mode_next = mode_reg;
        cal_next = cal_reg;
        // a long burst simply pushes old bits out the top
        if (sclk_rise && !load_s) begin
            shift_next = {shift_reg[WORD_W-2:0], sdata_s};
        end
        // the whole word is kept; fields are picked out below
        if (load_rise) begin
            case (shift_sel)
                ssc_pkg::SSC_SEL_REF: begin
                    ref_next = shift_reg;
                end
                ssc_pkg::SSC_SEL_DIV: begin
                    div_next = shift_reg;
                end
                ssc_pkg::SSC_SEL_MODE: begin
                    mode_next = shift_reg;
                end
                ssc_pkg::SSC_SEL_CAL: begin
                    cal_next = shift_reg;
                end
                default: begin
                    ref_next = ref_reg;
                end
            endcase
        end
    end

    // no reset is defined on the pins; words clear to zero here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= ssc_pkg::WORD_RST;
            ref_reg <= ssc_pkg::WORD_RST;
            div_reg <= ssc_pkg::WORD_RST;
            mode_reg <= ssc_pkg::WORD_RST;
            cal_reg <= ssc_pkg::WORD_RST;
        end else begin
            shift_reg <= shift_next;
            ref_reg <= ref_next;
            div_reg <= div_next;
            mode_reg <= mode_next;
            cal_reg <= cal_next;
        end
    end

    // field views; zero and don't-care bits are simply not used
    assign ref_count = ref_reg[ssc_pkg::REF_LSB +: REF_W];
    assign swallow_count = div_reg[ssc_pkg::SWAL_LSB +: SWAL_W];
    assign main_count = div_reg[ssc_pkg::MAIN_LSB +: MAIN_W];
    assign synth_power_bit = mode_reg[ssc_pkg::PWR_POS];
    assign prescaler_sel = mode_reg[ssc_pkg::PRESC_POS];
    assign cp_current = mode_reg[ssc_pkg::CPI_LSB +: 2];
    assign cp_sign = mode_reg[ssc_pkg::CPS_LSB +: 2];
    assign ld_select = {mode_reg[ssc_pkg::LDM_HI],
                        mode_reg[ssc_pkg::LDM_LSB +: 2]};
    assign cp_test = mode_reg[ssc_pkg::CPT_LSB +: 2];
    assign cal_count = cal_reg[ssc_pkg::CAL_LSB +: CAL_W];
    assign bias_sel = cal_reg[ssc_pkg::BIAS_POS];

    // ------------------------------------------------------------
    // power state decode
    // ------------------------------------------------------------

    ssc_pkg::ssc_pwr_t pwr_reg;
    ssc_pkg::ssc_pwr_t pwr_next;
    logic loop_reg;
    logic loop_next;

    // pins only matter while the power bit is set
    always_comb begin
        case ({pin1_s, pin2_s})
            2'h0: pwr_next = ssc_pkg::SSC_PWR_DOWN;
            2'h3: pwr_next = ssc_pkg::SSC_PWR_RX;
            2'h2: pwr_next = ssc_pkg::SSC_PWR_TX;
            default: pwr_next = ssc_pkg::SSC_PWR_IDLE;
        endcase
        if (!synth_power_bit) begin
            pwr_next = ssc_pkg::SSC_PWR_OFF;
        end
        loop_next = (pwr_next != ssc_pkg::SSC_PWR_OFF) &&
                    (pwr_next != ssc_pkg::SSC_PWR_DOWN);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= ssc_pkg::SSC_PWR_OFF;
            loop_reg <= 1'b0;
        end else begin
            pwr_reg <= pwr_next;
            loop_reg <= loop_next;
        end
    end

    assign power_state = pwr_reg;
    assign loop_active = loop_reg;
    assign rx_enable = (pwr_reg == ssc_pkg::SSC_PWR_RX);
    assign tx_enable = (pwr_reg == ssc_pkg::SSC_PWR_TX);

    // ------------------------------------------------------------
    // reference, feedback and calibration dividers
    // ------------------------------------------------------------

    logic [REF_W-1:0] rcnt_reg;   // reference edges seen
    logic [5:0] pcnt_reg;         // prescaler position
    logic [MAIN_W-1:0] mcnt_reg;  // prescaler cycles seen
    logic [CAL_W-1:0] ccnt_reg;   // calibration edges seen
    logic rpulse_reg;
    logic lpulse_reg;
    logic cpulse_reg;
    logic [REF_W-1:0] rcnt_next;
    logic [5:0] pcnt_next;
    logic [MAIN_W-1:0] mcnt_next;
    logic [CAL_W-1:0] ccnt_next;
    logic rpulse_next;
    logic lpulse_next;
    logic cpulse_next;
    logic [5:0] presc_mod;        // current prescaler modulus

    // prescaler divides by P+1 until the swallow count is used up,
    // then by P, so one main cycle spans P*B+A input edges
    always_comb begin
        presc_mod = prescaler_sel ? ssc_pkg::PRESC_HIGH
                                  : ssc_pkg::PRESC_LOW;
        if (mcnt_reg < MAIN_W'(swallow_count)) begin
            presc_mod = presc_mod + ssc_pkg::PRESC_ONE;
        end
        rcnt_next = rcnt_reg;
        pcnt_next = pcnt_reg;
        mcnt_next = mcnt_reg;
        ccnt_next = ccnt_reg;
        rpulse_next = 1'b0;
        lpulse_next = 1'b0;
        cpulse_next = 1'b0;
        // reference chain
        if (ref_rise) begin
            if (at_last(16'(rcnt_reg), 16'(ref_count))) begin
                rcnt_next = '0;
                rpulse_next = 1'b1;
            end else begin
                rcnt_next = rcnt_reg + 1'b1;
            end
        end
        // feedback chain; main below swallow is a host error
        if (lo_rise) begin
            if (at_last(16'(pcnt_reg), 16'(presc_mod))) begin
                pcnt_next = '0;
                if (at_last(16'(mcnt_reg), 16'(main_count))) begin
                    mcnt_next = '0;
                    lpulse_next = 1'b1;
                end else begin
                    mcnt_next = mcnt_reg + 1'b1;
                end
            end else begin
                pcnt_next = pcnt_reg + 1'b1;
            end
        end
        // loop dividers are held clear while the loop is off
        if (!loop_reg) begin
            rcnt_next = '0;
            pcnt_next = '0;
            mcnt_next = '0;
            rpulse_next = 1'b0;
            lpulse_next = 1'b0;
        end
        // calibration clock runs apart from loop power; zero is off
        if (ref_rise && (cal_count != '0)) begin
            if (at_last(16'(ccnt_reg), 16'(cal_count))) begin
                ccnt_next = '0;
                cpulse_next = 1'b1;
            end else begin
                ccnt_next = ccnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rcnt_reg <= '0;
            pcnt_reg <= '0;
            mcnt_reg <= '0;
            ccnt_reg <= '0;
            rpulse_reg <= 1'b0;
            lpulse_reg <= 1'b0;
            cpulse_reg <= 1'b0;
        end else begin
            rcnt_reg <= rcnt_next;
            pcnt_reg <= pcnt_next;
            mcnt_reg <= mcnt_next;
            ccnt_reg <= ccnt_next;
            rpulse_reg <= rpulse_next;
            lpulse_reg <= lpulse_next;
            cpulse_reg <= cpulse_next;
        end
    end

    assign ref_div_pulse = rpulse_reg;
    assign lo_div_pulse = lpulse_reg;
    assign cal_tick = cpulse_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    shift_sample_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        sclk_rise && !load_s |=> shift_reg[0] == $past(sdata_s)
    ) else $error("serial bit not taken on clock rise");

    shift_hold_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        load_s |=> $stable(shift_reg)
    ) else $error("shifter moved while strobe high");

    mode_load_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        load_rise && shift_sel == ssc_pkg::SSC_SEL_MODE
        |=> mode_reg == $past(shift_reg)
    ) else $error("mode word not loaded on strobe rise");

    ref_load_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        load_rise && shift_sel == ssc_pkg::SSC_SEL_REF
        |=> ref_reg == $past(shift_reg) && $stable(div_reg)
    ) else $error("reference word load wrong");

    div_load_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        load_rise && shift_sel == ssc_pkg::SSC_SEL_DIV
        |=> div_reg == $past(shift_reg) && $stable(cal_reg)
    ) else $error("divider word load wrong");

    cal_load_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        load_rise && shift_sel == ssc_pkg::SSC_SEL_CAL
        |=> cal_reg == $past(shift_reg) && $stable(mode_reg)
    ) else $error("calibration word load wrong");

    power_off_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        !synth_power_bit |=> !loop_active ##1 !ref_div_pulse
    ) else $error("loop active with power bit clear");

    power_down_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        synth_power_bit && !pin1_s && !pin2_s
        |=> power_state == ssc_pkg::SSC_PWR_DOWN && !loop_active
    ) else $error("power-down not entered");

    receive_state_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        synth_power_bit && pin1_s && pin2_s
        |=> rx_enable && !tx_enable && loop_active
    ) else $error("receive state not entered");

    transmit_state_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        synth_power_bit && pin1_s && !pin2_s
        |=> tx_enable && !rx_enable && loop_active
    ) else $error("transmit state not entered");

    idle_state_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        synth_power_bit && !pin1_s && pin2_s
        |=> !tx_enable && !rx_enable && loop_active
    ) else $error("idle state wrong");

    presc_range_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        pcnt_reg <= ssc_pkg::PRESC_HIGH
    ) else $error("prescaler count beyond largest modulus");

endmodule

/* tb/ssc_host_model.sv */
// host model: drives the three-wire config port of the synthesizer block
module ssc_host_model (
    // frame pacing clock
    input wire logic clock,
    // three-wire serial port
    output logic serial_clk,
    output logic serial_data,
    output logic load_strobe
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle: serial clock parked low, strobe high
    initial begin
        serial_clk = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b1;
    end

    // ------------------------------------------------------------
    // frames
    // ------------------------------------------------------------
    // n bits msb first, 160 ns per bit; sel low keeps the strobe high
    task automatic frame(input logic [23:0] b, input int n, input bit sel);
        @(posedge clock);
        #2 load_strobe = ~sel;
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = b[i];
            repeat (4) @(posedge clock);
            #2 serial_clk = 1'b1;
            repeat (4) @(posedge clock);
            #2 serial_clk = 1'b0;
        end
        // released line shows the inverse
        serial_data = ~serial_data;
        repeat (4) @(posedge clock);
        #2 load_strobe = 1'b1;
    endtask
endmodule

/* tb/tb_top.sv */
// testbench: config words, power decode and dividers of the config port
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    typedef struct {int k; logic [63:0] e;} sscp_note_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic serial_clk, serial_data, load_strobe;
    logic power_pin_first = 1'b0, power_pin_second = 1'b0;
    logic ref_in = 1'b0, lo_in = 1'b0;
    logic [14:0] ref_count, r_e = 15'h0000; // r_e and below: expected
    logic [6:0] swallow_count, cal_count, s_e = 7'h00, c_e = 7'h00;
    logic [10:0] main_count, m_e = 11'h000, md_e = 11'h000;
    logic synth_power_bit, prescaler_sel, bias_sel, b_e = 1'b0;
    logic [1:0] cp_current, cp_sign, cp_test;
    logic [2:0] ld_select;
    ssc_pkg::ssc_pwr_t power_state;
    logic loop_active, rx_enable, tx_enable;
    logic ref_div_pulse, lo_div_pulse, cal_tick;
    logic [15:0] n_ref = 16'h0000, n_lo = 16'h0000, n_cal = 16'h0000;
    logic [47:0] base;
    sscp_note_t q[$], nt;
    event look;
    int fails = 0, n_checks = 0;

    always #10 clock = ~clock;

    ssc_host_model host (.clock(clock), .serial_clk(serial_clk),
        .serial_data(serial_data), .load_strobe(load_strobe));

    ssc_config_port uut (.clock(clock), .rst_n(rst_n),
        .serial_clk(serial_clk), .serial_data(serial_data),
        .load_strobe(load_strobe), .power_pin_first(power_pin_first),
        .power_pin_second(power_pin_second), .ref_in(ref_in),
        .lo_in(lo_in), .ref_count(ref_count),
        .swallow_count(swallow_count), .main_count(main_count),
        .synth_power_bit(synth_power_bit), .prescaler_sel(prescaler_sel),
        .cp_current(cp_current), .cp_sign(cp_sign),
        .ld_select(ld_select), .cp_test(cp_test), .cal_count(cal_count),
        .bias_sel(bias_sel), .power_state(power_state),
        .loop_active(loop_active), .rx_enable(rx_enable),
        .tx_enable(tx_enable), .ref_div_pulse(ref_div_pulse),
        .lo_div_pulse(lo_div_pulse), .cal_tick(cal_tick));

    // pulses last one cycle: count every edge
    always @(posedge clock) begin
        if (ref_div_pulse === 1'b1) n_ref <= n_ref + 16'h0001;
        if (lo_div_pulse === 1'b1) n_lo <= n_lo + 16'h0001;
        if (cal_tick === 1'b1) n_cal <= n_cal + 16'h0001;
    end

    // ------------------------------------------------------------
    // expectations and comparisons
    // ------------------------------------------------------------
    function automatic logic [63:0] fld_now();
        return {12'h000, ref_count, swallow_count, main_count,
            synth_power_bit, prescaler_sel, cp_current, cp_sign, ld_select,
            cp_test, cal_count, bias_sel};
    endfunction
    function automatic logic [63:0] fld_exp();
        return {12'h000, r_e, s_e, m_e, md_e, c_e, b_e};
    endfunction
    // power state, loop, rx, tx
    function automatic logic [63:0] pw_e(input logic pb, p1, p2);
        logic [5:0] v;
        if (!pb) v = {ssc_pkg::SSC_PWR_OFF, 3'h0};
        else case ({p1, p2})
            2'h0: v = {ssc_pkg::SSC_PWR_DOWN, 3'h0};
            2'h3: v = {ssc_pkg::SSC_PWR_RX, 3'h6};
            2'h2: v = {ssc_pkg::SSC_PWR_TX, 3'h5};
            default: v = {ssc_pkg::SSC_PWR_IDLE, 3'h4};
        endcase
        return {58'h0, v};
    endfunction
    task automatic bad(input logic [63:0] got, e);
        fails++;
        $display("BAD %0t got %h want %h", $time, got, e);
    endtask
    task automatic cmp_fld(input logic [63:0] e);
        n_checks++;
        if (fld_now() !== e) bad(fld_now(), e);
    endtask
    task automatic cmp_pwr(input logic [63:0] e);
        logic [63:0] g;
        g = {58'h0, power_state, loop_active, rx_enable, tx_enable};
        n_checks++;
        if (g !== e) bad(g, e);
    endtask
    task automatic cmp_cnt(input logic [63:0] e);
        n_checks++;
        if ({16'h0000, n_ref, n_lo, n_cal} !== e) bad({n_ref, n_lo, n_cal}, e);
    endtask
    task automatic note(input int k, input logic [63:0] e);
        q.push_back('{k, e});
        ->look;
    endtask
    // monitor: oldest note first
    initial forever begin
        @(look);
        while (q.size() > 0) begin
            nt = q.pop_front();
            case (nt.k)
                0: cmp_fld(nt.e);
                1: cmp_pwr(nt.e);
                default: cmp_cnt(nt.e);
            endcase
        end
    end

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    // field outputs follow the strobe rise by three clocks, power status by four; five is safe
    task automatic settle();
        repeat (5) @(posedge clock);
        #2;
    endtask
    task automatic send(input logic [19:0] w);
        host.frame({4'h0, w}, 20, 1'b1);
        settle();
    endtask
    // mode word, other fields random
    task automatic wr_mode(input logic pw, ps);
        logic [31:0] r;
        r = $urandom;
        md_e = {pw, ps, r[8:0]};
        send({r[31:30], md_e[1:0], md_e[4], 4'h0, md_e[3:2], md_e[6:5],
            md_e[8:7], ps, 1'b0, pw, 2'h1});
    endtask
    task automatic wr_ref(input logic [14:0] v);
        logic [31:0] r;
        r = $urandom;
        r_e = v;
        send({r[2:0], v, 2'h0});
    endtask
    task automatic wr_div(input logic [6:0] s, input logic [10:0] m);
        s_e = s;
        m_e = m;
        send({m, s, 2'h2});
    endtask
    task automatic wr_cal(input logic [6:0] c, input logic b);
        logic [31:0] r;
        r = $urandom;
        c_e = c;
        b_e = b;
        send({r[5:0], b, 4'h0, c, 2'h3});
    endtask
    // n edges on ref_in or lo_in
    task automatic edges(input int n, input bit lo);
        repeat (n) begin
            {lo_in, ref_in} = lo ? 2'h2 : 2'h1;
            repeat (7) @(posedge clock);
            #2 {lo_in, ref_in} = 2'h0;
            repeat (7) @(posedge clock);
            #2;
        end
    endtask
    task automatic close_out();
        if (fails == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // hang guard; the run needs about 137 us
    initial begin
        #600us;
        fails++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(95209));
        repeat (12) @(posedge clock);
        #2 rst_n = 1'b1;
        settle();
        note(0, fld_exp());
        note(1, pw_e(1'b0, 1'b0, 1'b0));
        wr_mode(1'b1, 1'b0);
        note(0, fld_exp());
        // both range ends, counts three or more
        for (int i = 0; i < 2; i++) begin
            wr_ref(i ? 15'h7FFF : 15'h0003);
            note(0, fld_exp());
            wr_div(i ? 7'h7F : 7'h00, i ? 11'h7FF : 11'h003);
            note(0, fld_exp());
            wr_cal(7'($urandom), i[0]);
            note(0, fld_exp());
        end
        host.frame({4'h0, 20'($urandom)}, 20, 1'b0);
        host.frame(24'h000000, 0, 1'b1);
        settle();
        note(0, fld_exp());
        r_e = 15'(3 + $urandom % 32765);
        host.frame({4'($urandom), 3'h5, r_e, 2'h0}, 24, 1'b1);
        settle();
        note(0, fld_exp());
        // all pin pairs, power bit clear and set
        for (int i = 0; i < 8; i++) begin
            wr_mode(i[2], 1'b0);
            {power_pin_first, power_pin_second} = i[1:0];
            settle();
            note(1, pw_e(i[2], i[1], i[0]));
            note(0, fld_exp());
        end
        // dividers: ref by 3, cal by 5, lo by 16*3+1 then 32*3+1
        wr_ref(15'h0003);
        wr_div(7'h01, 11'h003);
        wr_cal(7'h05, 1'b1);
        {power_pin_first, power_pin_second} = 2'h0;
        settle();
        {power_pin_first, power_pin_second} = 2'h3;
        settle();
        base = {n_ref, n_lo, n_cal};
        edges(30, 1'b0);
        edges(98, 1'b1);
        wr_mode(1'b1, 1'b1);
        edges(97, 1'b1);
        settle();
        note(2, {16'h0000, base + {16'h000A, 16'h0003, 16'h0006}});
        #1 close_out();
    end
endmodule
